//--- src/sadc_pkg.sv
// Shared constants, types and register map for the converter control block
package sadc_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] SADC_CTRL_OFF  = 8'h00; // Enable, start, done, channel
  localparam logic [7:0] SADC_RESH_OFF  = 8'h04; // Result bits 11..4
  localparam logic [7:0] SADC_RESL_OFF  = 8'h08; // Gate, divider, result bits 3..0
  localparam logic [7:0] SADC_REF_OFF   = 8'h0C; // Reference and PWM trigger
  localparam logic [7:0] SADC_PIN_OFF   = 8'h10; // Pure analog pin configuration
  localparam logic [7:0] SADC_IRQ_OFF   = 8'h14; // Interrupt flag and enable
  // Field positions
  localparam int SADC_EN_BIT    = 7;
  localparam int SADC_START_BIT = 6;
  localparam int SADC_DONE_BIT  = 5;
  localparam int SADC_GATE_BIT  = 6;
  localparam int SADC_DIV_LSB   = 4;
  localparam int SADC_EXT_BIT   = 7;
  localparam int SADC_PWMT_BIT  = 4;
  localparam int SADC_IRQF_BIT  = 0;
  localparam int SADC_IRQE_BIT  = 1;
  // Channel codes
  localparam logic [3:0] SADC_CH_LAST   = 4'hC; // Highest valid code
  localparam logic [3:0] SADC_CH_OPAMP  = 4'hB;
  localparam logic [3:0] SADC_CH_BATT   = 4'hC;
  // Converter clock divider codes and terminal counts (fosc is aclk)
  localparam logic [1:0] SADC_DIV16 = 2'b00;
  localparam logic [1:0] SADC_DIV8  = 2'b01;
  localparam logic [1:0] SADC_DIV1  = 2'b10;
  localparam logic [1:0] SADC_DIV2  = 2'b11;
  localparam logic [3:0] SADC_TC16  = 4'hF;
  localparam logic [3:0] SADC_TC8   = 4'h7;
  localparam logic [3:0] SADC_TC1   = 4'h0;
  localparam logic [3:0] SADC_TC2   = 4'h1;
  // Conversion length: 16 periods of converter clock / 4
  localparam int         SADC_PERIODS    = 16;
  localparam int         SADC_PER_TICKS  = 4;
  localparam logic [5:0] SADC_LAST_STEP  = 6'(SADC_PERIODS * SADC_PER_TICKS - 1);
  localparam logic [3:0] SADC_SAMPLE_END = 4'h3; // Periods 0..3 sample
  localparam logic [11:0] SADC_MSB       = 12'h800;
  // Reset values
  localparam logic [3:0]  SADC_CH_RST  = 4'h0;
  localparam logic [1:0]  SADC_DIV_RST = 2'b00;
  localparam logic [1:0]  SADC_LVL_RST = 2'b00;
  localparam logic [15:0] SADC_PIN_RST = 16'h0000;
  // AXI responses
  localparam logic [1:0] SADC_OKAY   = 2'b00;
  localparam logic [1:0] SADC_SLVERR = 2'b10;
  // Software configuration carried together
  typedef struct packed {
    logic        enable;     // adc_enable
    logic [3:0]  channel;    // channel_select
    logic        gate;       // channel_gate
    logic [1:0]  divider;    // conv_clock_divider
    logic        ext_ref;    // ext_ref_select
    logic        pwm_trig;   // pwm_trigger_select
    logic [1:0]  ref_level;  // internal_ref_level
    logic        irq_en;     // converter_irq_enable
    logic [15:0] pin_analog; // pin_analog_config
  } sadc_cfg_t;
  // Converter sequencer states
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b01,
    SADC_CONV = 2'b10
  } sadc_state_t;
endpackage

//--- src/sadc_ctrl.sv
// SAR converter control with AXI4-Lite registers, sequencer and result buffer
`timescale 1ns/10ps
module sadc_ctrl
  import sadc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // System side
  input  wire logic        pwm_unit_enable,
  input  wire logic        cpu_idle,
  output logic             adc_irq,
  output logic             idle_wake,
  // Analog side
  input  wire logic        comp_in,
  output logic [11:0]      dac_code,
  output logic             sample_en,
  output logic [12:0]      channel_route,
  output logic [15:0]      pin_digital_off,
  output logic             ref_external,
  output logic [1:0]       ref_level
);

  sadc_cfg_t   cfg_q;          // Software configuration
  sadc_state_t state_q;        // Sequencer state
  logic        conv_start_q;   // Start bit
  logic        done_flag_q;    // conversion_done_flag
  logic        irq_flag_q;     // adc_irq_flag
  logic        pwm_mode_q;     // Current run came from the PWM trigger
  logic        pwm_en_q;       // Previous pwm_unit_enable for edge detect
  logic [3:0]  div_cnt_q;      // Converter clock prescaler
  logic        tick;           // One converter clock
  logic [5:0]  step_q;         // Converter clocks into conversion
  logic [11:0] code_q;         // Trial code
  logic [11:0] bit_q;          // Bit under test
  logic [11:0] result_q;       // Result buffer, no reset on purpose
  logic        comp_s1_q;      // Comparator synchroniser stage 1
  logic        comp_s2_q;      // Comparator synchroniser stage 2
  logic        wr_fire;        // Write taken this cycle
  logic        rd_fire;        // Read taken this cycle
  logic        sw_start;       // Software start request
  logic        pwm_start;      // PWM edge start request
  logic        finish;         // Last converter clock of a conversion
  logic        restart;        // PWM continuous restart
  logic [3:0]  div_tc;         // Prescaler terminal count
  logic [11:0] final_code;     // Code after the last decision

  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Comparator comes from the analog domain, so it is synchronised first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Write address and data are taken together, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SADC_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr <= SADC_IRQ_OFF && s_axi_awaddr[1:0] == 2'b00) begin
          s_axi_bresp <= SADC_OKAY;
        end else begin
          s_axi_bresp <= SADC_SLVERR; // Unmapped address
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration registers; result fields are read-only and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '{enable: 1'b0, channel: SADC_CH_RST, gate: 1'b0, divider: SADC_DIV_RST,
                 ext_ref: 1'b0, pwm_trig: 1'b0, ref_level: SADC_LVL_RST, irq_en: 1'b0,
                 pin_analog: SADC_PIN_RST};
    end else if (wr_fire && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == SADC_CTRL_OFF) begin
        cfg_q.enable  <= s_axi_wdata[SADC_EN_BIT];
        cfg_q.channel <= s_axi_wdata[3:0];
      end else if (s_axi_awaddr == SADC_RESL_OFF) begin
        cfg_q.gate    <= s_axi_wdata[SADC_GATE_BIT];
        cfg_q.divider <= s_axi_wdata[SADC_DIV_LSB +: 2];
      end else if (s_axi_awaddr == SADC_REF_OFF) begin
        cfg_q.ext_ref   <= s_axi_wdata[SADC_EXT_BIT];
        cfg_q.pwm_trig  <= s_axi_wdata[SADC_PWMT_BIT];
        cfg_q.ref_level <= s_axi_wdata[1:0];
      end else if (s_axi_awaddr == SADC_PIN_OFF) begin
        cfg_q.pin_analog[7:0] <= s_axi_wdata[7:0];
        // Upper pin byte rides on its own lane, written in the same beat
        if (s_axi_wstrb[1]) begin
          cfg_q.pin_analog[15:8] <= s_axi_wdata[15:8];
        end
      end else if (s_axi_awaddr == SADC_IRQ_OFF) begin
        cfg_q.irq_en <= s_axi_wdata[SADC_IRQE_BIT];
      end
    end else if (wr_fire && s_axi_wstrb[1] && s_axi_awaddr == SADC_PIN_OFF) begin
      cfg_q.pin_analog[15:8] <= s_axi_wdata[15:8];
    end
  end

  // Read data path, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SADC_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= SADC_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == SADC_CTRL_OFF) begin
          s_axi_rdata[7:0] <= {cfg_q.enable, conv_start_q, done_flag_q, 1'b0, cfg_q.channel};
        end else if (s_axi_araddr == SADC_RESH_OFF) begin
          s_axi_rdata[7:0] <= result_q[11:4];
        end else if (s_axi_araddr == SADC_RESL_OFF) begin
          s_axi_rdata[7:0] <= {1'b0, cfg_q.gate, cfg_q.divider, result_q[3:0]};
        end else if (s_axi_araddr == SADC_REF_OFF) begin
          s_axi_rdata[7:0] <= {cfg_q.ext_ref, 2'b00, cfg_q.pwm_trig, 2'b00, cfg_q.ref_level};
        end else if (s_axi_araddr == SADC_PIN_OFF) begin
          s_axi_rdata[15:0] <= cfg_q.pin_analog;
        end else if (s_axi_araddr == SADC_IRQ_OFF) begin
          s_axi_rdata[1:0] <= {cfg_q.irq_en, irq_flag_q};
        end else begin
          s_axi_rresp <= SADC_SLVERR; // Unmapped, reads zero
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Start sources, both gated by the enable bit
  assign sw_start  = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == SADC_CTRL_OFF &&
                     s_axi_wdata[SADC_START_BIT] && s_axi_wdata[SADC_EN_BIT];
  assign pwm_start = cfg_q.enable && cfg_q.pwm_trig && pwm_unit_enable && !pwm_en_q;
  assign finish    = state_q == SADC_CONV && tick && step_q == SADC_LAST_STEP;
  assign restart   = pwm_mode_q && pwm_unit_enable && cfg_q.enable;

  // PWM enable edge detector; the PWM unit shares aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_en_q <= 1'b0;
    end else begin
      pwm_en_q <= pwm_unit_enable;
    end
  end

  // Prescaler terminal count per divider code
  always_comb begin
    case (cfg_q.divider)
      SADC_DIV16: div_tc = SADC_TC16;
      SADC_DIV8:  div_tc = SADC_TC8;
      SADC_DIV1:  div_tc = SADC_TC1;
      default:    div_tc = SADC_TC2;
    endcase
  end
  assign tick = div_cnt_q == div_tc;

  // Prescaler restarts with each conversion so the length is exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 4'h0;
    end else if (state_q == SADC_IDLE || tick) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Sequencer; clearing the enable aborts a running conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= SADC_IDLE;
      step_q     <= 6'h00;
      pwm_mode_q <= 1'b0;
    end else begin
      case (state_q)
        SADC_IDLE: begin
          step_q <= 6'h00;
          if (sw_start || pwm_start) begin
            state_q    <= SADC_CONV;
            pwm_mode_q <= pwm_start && !sw_start;
          end
        end
        SADC_CONV: begin
          if (!cfg_q.enable) begin
            state_q <= SADC_IDLE;
          end else if (finish) begin
            step_q <= 6'h00;
            if (!restart) begin
              state_q <= SADC_IDLE;
            end
          end else if (tick) begin
            step_q <= step_q + 6'h01;
          end
        end
        default: state_q <= SADC_IDLE;
      endcase
    end
  end

  // Successive approximation: four sampling periods, then one bit per period
  assign final_code = comp_s2_q ? code_q : (code_q & ~bit_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= 12'h000;
      bit_q  <= 12'h000;
    end else if (state_q == SADC_CONV && tick && step_q[1:0] == 2'b11) begin
      if (step_q[5:2] == SADC_SAMPLE_END) begin
        code_q <= SADC_MSB;
        bit_q  <= SADC_MSB;
      end else if (step_q[5:2] > SADC_SAMPLE_END) begin
        code_q <= final_code | (bit_q >> 1);
        bit_q  <= bit_q >> 1;
      end
    end
  end

  // Result buffer loads only at the end, never with partial bits
  always_ff @(posedge aclk) begin
    if (finish) begin
      result_q <= final_code;
    end
  end

  // Start bit: set by software or PWM, cleared at completion, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start_q <= 1'b0;
    end else if (sw_start || pwm_start || (finish && restart)) begin
      conv_start_q <= 1'b1;
    end else if (finish || !cfg_q.enable) begin
      conv_start_q <= 1'b0;
    end
  end

  // Done and irq flags: hardware sets, software writes 0 to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
      irq_flag_q  <= 1'b0;
    end else begin
      if (finish) begin
        done_flag_q <= 1'b1;
      end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == SADC_CTRL_OFF &&
                   !s_axi_wdata[SADC_DONE_BIT]) begin
        done_flag_q <= 1'b0;
      end
      if (finish) begin
        irq_flag_q <= 1'b1;
      end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == SADC_IRQ_OFF &&
                   !s_axi_wdata[SADC_IRQF_BIT]) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt request and idle wake-up, both registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_irq   <= 1'b0;
      idle_wake <= 1'b0;
    end else begin
      adc_irq   <= cfg_q.irq_en && (irq_flag_q || finish);
      idle_wake <= cfg_q.irq_en && cpu_idle && finish;
    end
  end

  // Analog outputs, all from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code        <= 12'h000;
      sample_en       <= 1'b0;
      channel_route   <= 13'h0000;
      pin_digital_off <= SADC_PIN_RST;
      ref_external    <= 1'b0;
      ref_level       <= SADC_LVL_RST;
    end else begin
      dac_code  <= code_q;
      sample_en <= state_q == SADC_CONV && step_q[5:2] <= SADC_SAMPLE_END;
      if (cfg_q.gate && cfg_q.enable && cfg_q.channel <= SADC_CH_LAST) begin
        channel_route <= 13'h0001 << cfg_q.channel;
      end else begin
        channel_route <= 13'h0000;
      end
      pin_digital_off <= cfg_q.pin_analog;
      ref_external    <= cfg_q.ext_ref;
      ref_level       <= cfg_q.ref_level;
    end
  end

  // Checks
  sequence s_start;
    state_q == SADC_IDLE && (sw_start || pwm_start);
  endsequence
  sequence s_done;
    done_flag_q && irq_flag_q;
  endsequence

  property p_sw_start;
    @(posedge aclk) disable iff (!aresetn) sw_start && state_q == SADC_IDLE |=> state_q == SADC_CONV;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");

  property p_pwm_start;
    @(posedge aclk) disable iff (!aresetn) pwm_start && !sw_start && state_q == SADC_IDLE
      |=> pwm_mode_q && conv_start_q;
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("pwm start ignored");

  property p_continuous;
    @(posedge aclk) disable iff (!aresetn) finish && restart |=> state_q == SADC_CONV;
  endproperty
  a_continuous: assert property (p_continuous) else $error("pwm run stopped");

  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn) finish && !restart && !sw_start && !pwm_start
      |=> !conv_start_q;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit stuck");

  property p_done;
    @(posedge aclk) disable iff (!aresetn) finish |=> s_done ##0 result_q == $past(final_code);
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn) irq_flag_q && cfg_q.irq_en |=> adc_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_route;
    @(posedge aclk) disable iff (!aresetn) 1'b1 |-> $onehot0(channel_route) &&
      ($past(cfg_q.gate) || channel_route == 13'h0000);
  endproperty
  a_route: assert property (p_route) else $error("bad channel routing");

  property p_length;
    @(posedge aclk) disable iff (!aresetn) s_start ##1 (state_q == SADC_CONV && cfg_q.divider ==
      SADC_DIV1 && cfg_q.enable && !pwm_mode_q)[*8] |-> step_q == 6'd7;
  endproperty
  a_length: assert property (p_length) else $error("conversion pace wrong");

  property p_no_start_disabled;
    @(posedge aclk) disable iff (!aresetn) state_q == SADC_IDLE && !cfg_q.enable
      |=> state_q == SADC_IDLE;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("start while off");

  property p_result_stable;
    @(posedge aclk) disable iff (!aresetn) !$past(finish) && $past(aresetn) |-> $stable(result_q);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed early");

endmodule // sadc_ctrl

//--- sim/sadc_analog_model.sv
// Analog side model: one input level compared against the trial code
`timescale 1ns/10ps
module sadc_analog_model (
  input  wire logic        aclk,
  input  wire logic [11:0] level,
  input  wire logic [12:0] channel_route,
  input  wire logic [11:0] dac_code,
  output logic             comp_in
);
  logic toggle_q; // Junk pattern while nothing is routed

  // Unrouted input floats, so a changing value stands in for it
  always_ff @(posedge aclk) begin
    toggle_q <= ~toggle_q;
  end

  initial toggle_q = 1'b0;

  // Comparator is high when the input reaches the trial code
  assign comp_in = (|channel_route) ? (level >= dac_code) : toggle_q;
endmodule // sadc_analog_model

//--- sim/sadc_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sadc_ctrl_bench;
  import sadc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, pwm_en, cpu_idle, adc_irq, idle_wake, comp_in, sample_en, ref_external;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, ref_level;
  logic [11:0] dac_code, level;
  logic [12:0] channel_route;
  logic [15:0] pin_digital_off;
  int          err_total, checked, wake_cnt;
  logic [31:0] rd;
  logic [1:0]  rs;

  sadc_ctrl sadc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_unit_enable(pwm_en), .cpu_idle(cpu_idle), .adc_irq(adc_irq), .idle_wake(idle_wake),
    .comp_in(comp_in), .dac_code(dac_code), .sample_en(sample_en),
    .channel_route(channel_route), .pin_digital_off(pin_digital_off),
    .ref_external(ref_external), .ref_level(ref_level));

  sadc_analog_model sadc_analog_model_i (.aclk(aclk), .level(level),
    .channel_route(channel_route), .dac_code(dac_code), .comp_in(comp_in));

  // Clock at 25 MHz
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Completion pulses seen while idle
  always @(posedge aclk) if (idle_wake === 1'b1) wake_cnt++;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Write with address and data offered together; bready held until bvalid
  // Ready and valid are read mid-cycle, so they hold the value the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic hit_aw, hit_w, hit_b;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk);
      hit_aw = awready; hit_w = wready; hit_b = bvalid;
      @(posedge aclk);
      if (hit_aw === 1'b1) awvalid <= 1'b0;
      if (hit_w === 1'b1) wvalid <= 1'b0;
    end while (hit_b !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit_ar, hit_r;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk);
      hit_ar = arready; hit_r = rvalid;
      @(posedge aclk);
      if (hit_ar === 1'b1) arvalid <= 1'b0;
    end while (hit_r !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Lets registered outputs land before they are looked at
  task automatic settle;
    @(posedge aclk);
    #1;
  endtask

  task automatic t_reset;
    rd_reg(SADC_CTRL_OFF, rd, rs); cmp(rd, 32'h0000_0000);
    rd_reg(SADC_IRQ_OFF, rd, rs);  cmp(rd, 32'h0000_0000);
    rd_reg(8'h18, rd, rs); cmp({rd, 30'h0, rs}, {32'h0, 30'h0, SADC_SLVERR});
    wr(8'h1C, 32'h0000_00FF, rs); cmp(rs, SADC_SLVERR);
  endtask

  // Every channel code, gate on and off, reference and pin fields
  task automatic t_route;
    for (int c = 0; c < 16; c++) begin
      wr(SADC_RESL_OFF, 32'h0000_0060, rs);
      wr(SADC_CTRL_OFF, 32'h80 | c, rs);
      settle();
      cmp(channel_route, (c <= 12) ? (13'h1 << c) : 13'h0);
      cmp($countones(channel_route) <= 1, 1);
      wr(SADC_RESL_OFF, 32'h0000_0020, rs);
      settle();
      cmp(channel_route, 13'h0);
    end
    for (int v = 0; v < 8; v++) begin
      wr(SADC_REF_OFF, {24'h0, v[2], 5'h0, v[1:0]}, rs);
      settle();
      cmp({ref_external, ref_level}, v[2:0]);
    end
    wr(SADC_PIN_OFF, 32'h0000_A5C3, rs);
    settle();
    cmp(pin_digital_off, 16'hA5C3);
    wr(SADC_PIN_OFF, 32'h0000_0000, rs);
  endtask

  // One software conversion: length, flags, split result, self-clearing start
  task automatic t_conv(input logic [1:0] dv, input logic [11:0] lv, input int n);
    int k;
    level = lv;
    wr(SADC_REF_OFF, 32'h0000_0003, rs);
    wr(SADC_IRQ_OFF, 32'h0000_0002, rs);
    wr(SADC_RESL_OFF, {24'h0, 2'b01, dv, 4'h0}, rs);
    wr(SADC_RESH_OFF, 32'h0000_0000, rs);
    wr(SADC_CTRL_OFF, 32'h0000_00C1, rs);
    k = 0;
    while (adc_irq !== 1'b1 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    cmp(k >= n - 3 && k <= n + 3, 1);
    rd_reg(SADC_CTRL_OFF, rd, rs); cmp(rd[7:0], 8'hA1);
    rd_reg(SADC_RESH_OFF, rd, rs); cmp(rd[7:0], lv[11:4]);
    rd_reg(SADC_RESL_OFF, rd, rs); cmp(rd[7:0], {2'b01, dv, lv[3:0]});
    rd_reg(SADC_IRQ_OFF, rd, rs); cmp(rd[1:0], 2'b11);
    wr(SADC_IRQ_OFF, 32'h0000_0002, rs);
    settle();
    cmp(adc_irq, 1'b0);
    wr(SADC_CTRL_OFF, 32'h0000_0081, rs);
    rd_reg(SADC_CTRL_OFF, rd, rs); cmp(rd[7:0], 8'h81);
  endtask

  // Starts with the converter off, software or PWM, do nothing
  task automatic t_disabled;
    wr(SADC_REF_OFF, 32'h0000_0013, rs);
    wr(SADC_CTRL_OFF, 32'h0000_0041, rs);
    pwm_en <= 1'b1;
    repeat (200) @(posedge aclk);
    pwm_en <= 1'b0;
    rd_reg(SADC_IRQ_OFF, rd, rs); cmp(rd[1:0], 2'b10);
    rd_reg(SADC_CTRL_OFF, rd, rs); cmp(rd[5], 1'b0);
  endtask

  // PWM enable trigger repeats while high and wakes an idle CPU
  task automatic t_pwm;
    level = 12'h5A3;
    cpu_idle <= 1'b1;
    wr(SADC_RESL_OFF, 32'h0000_0060, rs);
    wr(SADC_CTRL_OFF, 32'h0000_0081, rs);
    wr(SADC_REF_OFF, 32'h0000_0003, rs);
    pwm_en <= 1'b1;
    repeat (300) @(posedge aclk);
    cmp(wake_cnt, 0);
    pwm_en <= 1'b0;
    wr(SADC_REF_OFF, 32'h0000_0013, rs);
    wake_cnt = 0;
    pwm_en <= 1'b1;
    repeat (280) @(posedge aclk);
    cmp(wake_cnt >= 3, 1);
    pwm_en <= 1'b0;
    repeat (80) @(posedge aclk);
    wake_cnt = 0;
    repeat (200) @(posedge aclk);
    cmp(wake_cnt, 0);
    cpu_idle <= 1'b0;
  endtask

  // Cuts a hang short
  initial begin
    #(40 * 60000);
    err_total++;
    end_sim();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pwm_en, cpu_idle} = 8'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; level = 12'h000;
    err_total = 0; checked = 0; wake_cnt = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_route();
    t_conv(SADC_DIV1, 12'h000, 64);
    t_conv(SADC_DIV1, 12'hFFF, 64);
    t_conv(SADC_DIV2, 12'h5A3, 128);
    t_conv(SADC_DIV8, 12'h3C9, 512);
    t_conv(SADC_DIV16, 12'h801, 1024);
    t_disabled();
    t_pwm();
    end_sim();
  end
endmodule // sadc_ctrl_bench
